// ### common/npic_pkg.sv
/*
  Shared constants and types of the nested priority interrupt controller:
  level encodings, vector addresses, priority register layout, states.
  Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
`default_nettype none

package npic_pkg;

  // vector table shape
  localparam int NPIC_NVEC     = 14;  // maskable vectors
  localparam int NPIC_IDX_W    = 4;
  localparam int NPIC_NEXT     = 4;   // external line groups
  localparam int NPIC_GRP_PINS = 4;   // pins per group
  localparam int NPIC_EXT_BASE = 2;   // first vector used by the groups
  localparam int NPIC_NREG     = 4;   // priority registers
  localparam int NPIC_FLD_W    = 2;   // level field width

  // level codes as {level_high_bit, level_low_bit}
  localparam logic [1:0] NPIC_LVL0 = 2'h2;
  localparam logic [1:0] NPIC_LVL1 = 2'h1;
  localparam logic [1:0] NPIC_LVL2 = 2'h0;
  localparam logic [1:0] NPIC_LVL3 = 2'h3;

  // level bit positions in the condition code register
  localparam int NPIC_CC_HI_POS = 5;
  localparam int NPIC_CC_LO_POS = 3;

  // fixed vector addresses, top of memory
  localparam logic [15:0] NPIC_VEC_RESET = 16'hFFFE;
  localparam logic [15:0] NPIC_VEC_TRAP  = 16'hFFFC;
  localparam logic [15:0] NPIC_VEC_TOP   = 16'hFFFA;  // vector 0
  localparam logic [15:0] NPIC_VEC_FLOOR = 16'hFFE0;

  // priority register reset value and read-only top nibble
  localparam logic [7:0] NPIC_PRIO_RST  = 8'hFF;
  localparam logic [7:0] NPIC_PRIO3_RO  = 8'hF0;

  // halt-capable vectors: time base, external groups, serial port
  localparam logic [NPIC_NVEC-1:0] NPIC_HALT_CAP = 14'h00BE;

  typedef enum logic [1:0] {
    NPIC_ST_RESET,
    NPIC_ST_RUN,
    NPIC_ST_STACK,
    NPIC_ST_ENTER
  } npic_state_t;

endpackage : npic_pkg

`default_nettype wire

// ### hw/npic_arb.sv
/*
  Priority decision of the interrupt controller: software level first,
  fixed hardware order second (vector 0 highest), trap above all.
  Assumes requests already masked by enable and by any halt restriction.
*/
`timescale 1ns/100ps
`default_nettype none

module npic_arb (
  // requests and settings
  input  wire logic [npic_pkg::NPIC_NVEC-1:0]   i_req,
  input  wire logic [2*npic_pkg::NPIC_NVEC-1:0] i_prio,
  input  wire logic [1:0]                       i_cur_lvl,
  input  wire logic                             i_trap,
  // decision
  output logic                                  o_valid,
  output logic                                  o_nmi,
  output logic [npic_pkg::NPIC_IDX_W-1:0]       o_idx,
  output logic [1:0]                            o_lvl
);
  import npic_pkg::*;

  logic [1:0] best;

  // code to rank: 10 -> 0, 01 -> 1, 00 -> 2, 11 -> 3
  function automatic logic [1:0] lvl_num(input logic [1:0] c);
    unique case (c)
      NPIC_LVL0: lvl_num = 2'h0;
      NPIC_LVL1: lvl_num = 2'h1;
      NPIC_LVL2: lvl_num = 2'h2;
      NPIC_LVL3: lvl_num = 2'h3;
    endcase
  endfunction : lvl_num

  // scan low hardware priority first so ties fall to the lower index
  always_comb begin
    o_valid = 1'b0;
    o_nmi   = 1'b0;
    o_idx   = '0;
    o_lvl   = NPIC_LVL3;
    best    = 2'h0;
    for (int v = NPIC_NVEC - 1; v >= 0; v--) begin
      if (i_req[v] && (lvl_num(i_prio[2*v +: 2]) > lvl_num(i_cur_lvl))
          && (!o_valid || lvl_num(i_prio[2*v +: 2]) >= best)) begin
        o_valid = 1'b1;
        best    = lvl_num(i_prio[2*v +: 2]);
        o_idx   = NPIC_IDX_W'(v);
        o_lvl   = i_prio[2*v +: 2];
      end
    end
    // trap ranks above every level, even level 3
    if (i_trap) begin
      o_valid = 1'b1;
      o_nmi   = 1'b1;
    end
  end

endmodule : npic_arb

`default_nettype wire

// ### hw/npic_ctrl.sv
/*
  Nested priority interrupt controller: request latches, priority
  registers, current level, entry and return sequencing, wait and halt.
  Assumes the core pulses i_instr_boundary at each instruction end,
  pushes the context on o_stack_req and answers with i_stack_done.
*/
// Functional notes
// - level held as bits 5,3 with fixed codes
// - finish instruction, then stack PC X A CC
// - maskable entry loads vector's priority field
// - after stacking, load vector address into PC
// - return pops level bits, restoring prior level
// - highest software level wins, hardware breaks ties
// - unserved requests stay latched until highest
// - reset and trap ignore level, rank top
// - non-maskable entry forces level 3
// - trap instruction raises trap, same sequence
// - reset and trap end halt mode
// - maskable needs enable and strictly higher level
// - edge pin request latched, cleared on entry
// - selected pins of a group are ORed
// - peripheral request is flag AND enable
// - clearing sequence discards pending peripheral request
// - all wake wait; only capable sources end halt
// - first service after halt is halt-capable
// - blocked higher request served right after
// - sixteen vectors fixed from FFE0 to FFFF
// - after reset run at level 3
// - software instructions may rewrite level bits
// - priority registers reset to ones, last one's top nibble fixed
// - writes of level 0 code are ignored
`timescale 1ns/100ps
`default_nettype none

module npic_ctrl #(
  parameter logic [npic_pkg::NPIC_NVEC-1:0] HALT_CAP = npic_pkg::NPIC_HALT_CAP
) (
  // clock and reset
  input  wire logic                                       i_sys_clk,
  input  wire logic                                       i_resetn,
  // core sequencing
  input  wire logic                                       i_instr_boundary,
  input  wire logic                                       i_stack_done,
  input  wire logic                                       i_trap_instr,
  input  wire logic                                       i_enter_wait,
  input  wire logic                                       i_enter_halt,
  input  wire logic                                       i_cc_load,
  input  wire logic                                       i_irq_return,
  input  wire logic [1:0]                                 i_cc_bits,
  // priority register port
  input  wire logic                                       i_prio_wr,
  input  wire logic [1:0]                                 i_prio_addr,
  input  wire logic [7:0]                                 i_prio_wdata,
  input  wire logic [1:0]                                 i_prio_raddr,
  // request sources
  input  wire logic [npic_pkg::NPIC_NEXT*npic_pkg::NPIC_GRP_PINS-1:0] i_ext_pins,
  input  wire logic [npic_pkg::NPIC_NEXT*npic_pkg::NPIC_GRP_PINS-1:0] i_ext_sel,
  input  wire logic [npic_pkg::NPIC_NVEC-1:0]             i_per_flag,
  input  wire logic [npic_pkg::NPIC_NVEC-1:0]             i_per_en,
  input  wire logic [npic_pkg::NPIC_NVEC-1:0]             i_per_clear,
  // to the core
  output logic                                            o_level_high_bit,
  output logic                                            o_level_low_bit,
  output logic                                            o_stack_req,
  output logic                                            o_vec_load,
  output logic [15:0]                                     o_vector_addr,
  output logic                                            o_wait_mode,
  output logic                                            o_halt_mode,
  output logic [7:0]                                      o_prio_rdata,
  output logic [npic_pkg::NPIC_NVEC-1:0]                  o_pending
);
  import npic_pkg::*;

  typedef struct packed {
    npic_state_t                  st;
    logic [1:0]                   lvl;
    logic [NPIC_NEXT-1:0]         grp_prev;
    logic [NPIC_NEXT-1:0]         ext_pend;
    logic [NPIC_NVEC-1:0]         per_pend;
    logic                         trap_pend;
    logic [NPIC_NREG-1:0][7:0]    prio;
    logic                         stack_req;
    logic                         vec_load;
    logic [15:0]                  vec;
    logic                         waitm;
    logic                         haltm;
    logic                         halt_first;
    logic [7:0]                   rdata;
    logic                         sel_nmi;
    logic [NPIC_IDX_W-1:0]        sel_idx;
    logic [1:0]                   sel_lvl;
    logic [NPIC_NVEC-1:0]         pend;
  } npic_regs_t;

  npic_regs_t                q;
  npic_regs_t                d;
  logic [NPIC_NEXT-1:0]      grp;
  logic [NPIC_NEXT-1:0]      ext_edge;
  logic [NPIC_NEXT-1:0]      ext_clr;
  logic [NPIC_NVEC-1:0]      req;
  logic [NPIC_NVEC-1:0]      arb_req;
  logic [31:0]               prio_flat;
  logic                      arb_valid;
  logic                      arb_nmi;
  logic [NPIC_IDX_W-1:0]     arb_idx;
  logic [1:0]                arb_lvl;

  // one request line per pin group
  for (genvar g = 0; g < NPIC_NEXT; g++) begin : g_grp
    assign grp[g] = |(i_ext_pins[g*NPIC_GRP_PINS +: NPIC_GRP_PINS]
                    & i_ext_sel[g*NPIC_GRP_PINS +: NPIC_GRP_PINS]);
  end

  // pending maskable requests, peripherals gated by their enables
  assign ext_edge  = grp & ~q.grp_prev;
  assign req       = (q.per_pend & i_per_en)
                   | (NPIC_NVEC'(q.ext_pend) << NPIC_EXT_BASE);
  assign arb_req   = q.halt_first ? (req & HALT_CAP) : req;
  assign prio_flat = q.prio;
  assign ext_clr   = NPIC_NEXT'((NPIC_NVEC'(1) << q.sel_idx) >> NPIC_EXT_BASE);

  npic_arb u_arb (
    .i_req     (arb_req),
    .i_prio    (prio_flat[2*NPIC_NVEC-1:0]),
    .i_cur_lvl (q.lvl),
    .i_trap    (q.trap_pend),
    .o_valid   (arb_valid),
    .o_nmi     (arb_nmi),
    .o_idx     (arb_idx),
    .o_lvl     (arb_lvl)
  );

  // next state
  always_comb begin
    d          = q;
    d.vec_load = 1'b0;
    d.grp_prev = grp;
    d.ext_pend = q.ext_pend | ext_edge;
    // clearing sequence beats a new flag, as the peripheral intends
    d.per_pend = (q.per_pend | (i_per_flag & i_per_en)) & ~i_per_clear;
    if (i_trap_instr) begin
      d.trap_pend = 1'b1;
    end
    d.rdata = q.prio[i_prio_raddr];
    // level 0 code in a field leaves that field as it was
    if (i_prio_wr) begin
      for (int k = 0; k < NPIC_NREG; k++) begin
        if (i_prio_wdata[2*k +: 2] != NPIC_LVL0) begin
          d.prio[i_prio_addr][2*k +: 2] = i_prio_wdata[2*k +: 2];
        end
      end
    end
    d.prio[NPIC_NREG-1] = d.prio[NPIC_NREG-1] | NPIC_PRIO3_RO;
    // wake-up; halt exit limits the next choice to capable sources
    if (q.waitm && ((|req) || q.trap_pend)) begin
      d.waitm = 1'b0;
    end
    if (q.haltm && ((|(req & HALT_CAP)) || q.trap_pend)) begin
      d.haltm      = 1'b0;
      d.halt_first = 1'b1;
    end
    unique case (q.st)
      NPIC_ST_RESET: begin
        d.vec      = NPIC_VEC_RESET;
        d.lvl      = NPIC_LVL3;
        d.vec_load = 1'b1;
        d.st       = NPIC_ST_RUN;
      end
      NPIC_ST_RUN: begin
        if (i_cc_load || i_irq_return) begin
          d.lvl = i_cc_bits;
        end
        if (i_enter_wait) begin
          d.waitm = 1'b1;
          d.lvl   = NPIC_LVL0;
        end
        if (i_enter_halt) begin
          d.haltm = 1'b1;
          d.lvl   = NPIC_LVL0;
        end
        // decide once, at the boundary, and freeze the choice
        if (i_instr_boundary && arb_valid && !q.waitm && !q.haltm) begin
          d.sel_nmi   = arb_nmi;
          d.sel_idx   = arb_idx;
          d.sel_lvl   = arb_lvl;
          d.stack_req = 1'b1;
          d.st        = NPIC_ST_STACK;
        end
      end
      NPIC_ST_STACK: begin
        if (i_stack_done) begin
          d.stack_req = 1'b0;
          d.st        = NPIC_ST_ENTER;
        end
      end
      NPIC_ST_ENTER: begin
        d.vec_load   = 1'b1;
        d.st         = NPIC_ST_RUN;
        d.halt_first = 1'b0;
        if (q.sel_nmi) begin
          d.vec       = NPIC_VEC_TRAP;
          d.lvl       = NPIC_LVL3;
          d.trap_pend = i_trap_instr;
        end else begin
          d.vec      = NPIC_VEC_TOP - {11'h000, q.sel_idx, 1'b0};
          d.lvl      = q.sel_lvl;
          d.ext_pend = (q.ext_pend & ~ext_clr) | ext_edge;
        end
      end
    endcase
    // pending view registered so the output never follows an enable glitch
    d.pend = (d.per_pend & i_per_en)
           | (NPIC_NVEC'(d.ext_pend) << NPIC_EXT_BASE);
  end

  // all state in one register
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q            <= '0;
      q.st         <= NPIC_ST_RESET;
      q.lvl        <= NPIC_LVL3;
      q.prio       <= {NPIC_NREG{NPIC_PRIO_RST}};
      q.vec        <= NPIC_VEC_RESET;
      q.rdata      <= NPIC_PRIO_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign o_level_high_bit = q.lvl[1];
  assign o_level_low_bit  = q.lvl[0];
  assign o_stack_req      = q.stack_req;
  assign o_vec_load       = q.vec_load;
  assign o_vector_addr    = q.vec;
  assign o_wait_mode      = q.waitm;
  assign o_halt_mode      = q.haltm;
  assign o_prio_rdata     = q.rdata;
  assign o_pending        = q.pend;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  // checks
  a_nmi_entry_lvl: assert property (
    o_vec_load && (o_vector_addr == NPIC_VEC_TRAP) |-> (q.lvl == NPIC_LVL3))
    else $error("trap entry without level 3");
  a_mask_entry_lvl: assert property (
    o_vec_load && (o_vector_addr < NPIC_VEC_TRAP)
      |-> (q.lvl == prio_flat[2*q.sel_idx +: 2]))
    else $error("entry level differs from vector field");
  // the enter cycle sits between the last stack request and the load
  a_stack_before: assert property (
    o_vec_load && (o_vector_addr != NPIC_VEC_RESET) |-> $past(o_stack_req, 2))
    else $error("vector loaded without stacking");
  a_stack_hold: assert property (
    o_stack_req && !i_stack_done |=> o_stack_req)
    else $error("stack request dropped early");
  a_vec_range: assert property (
    o_vec_load |-> (o_vector_addr >= NPIC_VEC_FLOOR) && !o_vector_addr[0])
    else $error("vector outside table");
  a_vec_single: assert property (
    o_vec_load |=> !o_vec_load ##1 !o_vec_load)
    else $error("two vector loads in a row");
  a_per_clear: assert property (
    |i_per_clear |=> ((q.per_pend & $past(i_per_clear)) == '0))
    else $error("cleared request still pending");
  a_prio_ro: assert property (
    (q.prio[NPIC_NREG-1] & NPIC_PRIO3_RO) == NPIC_PRIO3_RO)
    else $error("read-only priority bits changed");
  a_halt_wake: assert property (
    o_halt_mode && (|(req & HALT_CAP)) |=> !o_halt_mode)
    else $error("capable request left halt standing");
  a_wait_wake: assert property (
    o_wait_mode && (|req) |=> !o_wait_mode)
    else $error("request left wait standing");
  a_return_lvl: assert property (
    i_irq_return && (q.st == NPIC_ST_RUN) && !i_enter_wait && !i_enter_halt
      |=> (q.lvl == $past(i_cc_bits)))
    else $error("return did not restore level");
  a_lvl0_write: assert property (
    i_prio_wr && (i_prio_wdata == 8'hAA) |=> $stable(q.prio))
    else $error("level 0 write changed a field");
  // halt may end only on a capable source or the trap
  a_halt_hold: assert property (
    o_halt_mode && !(|(req & HALT_CAP)) && !q.trap_pend |=> o_halt_mode)
    else $error("halt ended without a capable source");
  a_trap_wake: assert property (
    o_halt_mode && q.trap_pend |=> !o_halt_mode)
    else $error("trap left halt standing");

  // main paths: entries, nesting, wake-ups
  c_mask_entry: cover property (o_vec_load && (o_vector_addr < NPIC_VEC_TRAP));
  c_trap_entry: cover property (o_vec_load && (o_vector_addr == NPIC_VEC_TRAP));
  c_halt_exit:  cover property ($fell(o_halt_mode));
  c_nested:     cover property (o_stack_req && (q.lvl != NPIC_LVL0));
  c_wait_exit:  cover property ($fell(o_wait_mode));

endmodule : npic_ctrl

`default_nettype wire

// ### dv/npic_core_model.sv
/*
  Behavioural model of the processor core's stacking side: answers each
  stack request with one done pulse after a chosen number of cycles.
  Assumes the controller holds o_stack_req until the edge after done.
*/
`timescale 1ns/100ps
`default_nettype none

module npic_core_model (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  // stacking handshake
  input  wire logic       i_stack_req,
  input  wire logic [3:0] i_delay,
  output logic            o_stack_done
);
  logic [3:0] cnt_q;
  logic       busy_q;
  logic       hold_q;

  // push PC, X, A, CC; hold off until the request drops so one request
  // never earns two done pulses
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q        <= 4'h0;
      busy_q       <= 1'b0;
      hold_q       <= 1'b0;
      o_stack_done <= 1'b0;
    end else begin
      o_stack_done <= 1'b0;
      if (hold_q && !i_stack_req) begin
        hold_q <= 1'b0;
      end
      if (!busy_q && !hold_q && i_stack_req) begin
        busy_q <= 1'b1;
        cnt_q  <= i_delay;
      end else if (busy_q && cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (busy_q) begin
        busy_q       <= 1'b0;
        hold_q       <= 1'b1;
        o_stack_done <= 1'b1;
      end
    end
  end
endmodule : npic_core_model

`default_nettype wire

// ### dv/npic_ctrl_tb.sv
/*
  Self-checking bench of the interrupt controller: reset, priority regs,
  random arbitration and nesting, trap, pins, clearing, wait and halt.
  Assumes npic_pkg and the core model; outputs sampled at falling edges, wait and halt flags at rising edges.
*/
`timescale 1ns/100ps
`default_nettype none

module npic_ctrl_tb;
  import npic_pkg::*;
  logic                 sys_clk, rstn, bnd, sdone, trap, ewait, ehalt, ccl, irq_return_instr, pwr;
  logic                 lh, ll, sreq, vload, wm, hm;
  logic [1:0]           ccb, paddr, praddr;
  logic [7:0]           pwd, prd;
  logic [15:0]          pins, sel, vaddr;
  logic [NPIC_NVEC-1:0] flag, en, clr, pend, m;
  logic [3:0]           dly;
  logic [1:0]           fld [16];
  logic [31:0]          rs;
  int                   mismatches = 0, cmp_count = 0, cyc = 0, w, w2;

  npic_ctrl DUT (.i_sys_clk(sys_clk), .i_resetn(rstn), .i_instr_boundary(bnd),
    .i_stack_done(sdone), .i_trap_instr(trap), .i_enter_wait(ewait), .i_enter_halt(ehalt),
    .i_cc_load(ccl), .i_irq_return(irq_return_instr), .i_cc_bits(ccb), .i_prio_wr(pwr),
    .i_prio_addr(paddr), .i_prio_wdata(pwd), .i_prio_raddr(praddr), .i_ext_pins(pins),
    .i_ext_sel(sel), .i_per_flag(flag), .i_per_en(en), .i_per_clear(clr),
    .o_level_high_bit(lh), .o_level_low_bit(ll), .o_stack_req(sreq), .o_vec_load(vload),
    .o_vector_addr(vaddr), .o_wait_mode(wm), .o_halt_mode(hm), .o_prio_rdata(prd),
    .o_pending(pend));

  npic_core_model core (.i_sys_clk(sys_clk), .i_resetn(rstn), .i_stack_req(sreq),
    .i_delay(dly), .o_stack_done(sdone));

  // 25 MHz clock and a hang limit well above the expected run
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      end_sim();
    end
  end

  // expectation helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int rk(input logic [1:0] c);  // code to nesting rank
    if (c == NPIC_LVL0) return 0;
    if (c == NPIC_LVL1) return 1;
    if (c == NPIC_LVL2) return 2;
    return 3;
  endfunction : rk
  function automatic int win(input logic [13:0] r, input logic [1:0] cur);
    int b;
    b = 15;
    for (int v = 0; v < NPIC_NVEC; v++)
      if (r[v] && rk(fld[v]) > rk(cur) && (b == 15 || rk(fld[v]) > rk(fld[b]))) b = v;
    return b;
  endfunction : win
  function automatic logic [15:0] va(input int v);
    return NPIC_VEC_TOP - 16'(2 * v);
  endfunction : va

  task automatic end_sim();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : step
  task automatic pw(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    pwr   <= 1'b1;
    paddr <= a;
    pwd   <= d;
    @(posedge sys_clk);
    pwr   <= 1'b0;
  endtask : pw
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    praddr <= a;
    step(1);
    @(negedge sys_clk);
    chk("prio_rdata", {8'h00, e}, {8'h00, prd});
  endtask : rd
  task automatic wfld();
    for (int r = 0; r < NPIC_NREG; r++)
      pw(2'(r), {fld[4*r+3], fld[4*r+2], fld[4*r+1], fld[4*r]});
  endtask : wfld
  // r=0 level load by enable/disable/pop, r=1 interrupt return
  task automatic ccw(input logic [1:0] c, input logic r);
    @(posedge sys_clk);
    ccb  <= c;
    ccl  <= ~r;
    irq_return_instr <= r;
    @(posedge sys_clk);
    ccl  <= 1'b0;
    irq_return_instr <= 1'b0;
    @(negedge sys_clk);
    chk("level", {14'h0, c}, {14'h0, lh, ll});
  endtask : ccw
  // ev of zero means no entry may happen
  task automatic wvl(input logic [15:0] ev, input logic [1:0] el);
    int k;
    k = 0;
    @(negedge sys_clk);
    while (vload !== 1'b1 && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    chk("vec_load", {15'h0, ev != 16'h0}, {15'h0, vload});
    if (ev != 16'h0) begin
      chk("vector", ev, vaddr);
      chk("level", {14'h0, el}, {14'h0, lh, ll});
    end
  endtask : wvl
  task automatic serve(input logic [15:0] ev, input logic [1:0] el);
    rs = xs(rs);
    @(posedge sys_clk);
    bnd <= 1'b1;
    dly <= rs[3:0];
    @(posedge sys_clk);
    bnd <= 1'b0;
    @(negedge sys_clk);
    chk("stack_req", {15'h0, ev != 16'h0}, {15'h0, sreq});
    wvl(ev, el);
  endtask : serve
  task automatic pulse_trap();
    @(posedge sys_clk);
    trap <= 1'b1;
    @(posedge sys_clk);
    trap <= 1'b0;
  endtask : pulse_trap

  // main sequence
  initial begin
    rs = 32'h34007096;
    {rstn, bnd, trap, ewait, ehalt, ccl, irq_return_instr, pwr} = 8'h00;
    {ccb, paddr, praddr, pwd, dly} = 18'h0;
    {pins, sel} = 32'h0;
    {flag, en, clr} = 42'h0;
    for (int i = 0; i < 16; i++) fld[i] = NPIC_LVL3;
    step(16);
    rstn <= 1'b1;
    wvl(NPIC_VEC_RESET, NPIC_LVL3);
    for (int r = 0; r < 4; r++) rd(2'(r), NPIC_PRIO_RST);
    pw(2'h0, 8'hCF);
    pw(2'h0, 8'h64);
    rd(2'h0, 8'h44);
    pw(2'h3, 8'h00);
    rd(2'h3, 8'hF0);
    pw(2'h1, 8'hAA);
    rd(2'h1, 8'hFF);
    en <= '1;
    // random priorities and request sets, then a check of the nested entry that follows, if any
    for (int it = 0; it < 24; it++) begin
      for (int v = 0; v < NPIC_NVEC; v++) begin
        rs = xs(rs);
        fld[v] = (rs[1:0] == NPIC_LVL0) ? NPIC_LVL3 : rs[1:0];
      end
      rs = xs(rs);
      m = rs[13:0] & rs[27:14];
      if (m == 14'h0) m = 14'h0040;
      wfld();
      ccw(NPIC_LVL0, 1'b0);
      flag <= m;
      step(2);
      @(negedge sys_clk);
      chk("pending", {2'h0, m}, {2'h0, pend});
      w  = win(m, NPIC_LVL0);
      serve(va(w), fld[w]);
      w2 = win(m, fld[w]);
      serve(w2 == 15 ? 16'h0 : va(w2), w2 == 15 ? 2'h0 : fld[w2]);
      flag <= '0;
      clr  <= m;
      step(1);
      clr  <= '0;
      ccw(fld[w], 1'b1);
    end
    // trap at level 3 beats a pending maskable request
    flag <= 14'h0200;
    ccw(NPIC_LVL3, 1'b0);
    pulse_trap();
    serve(NPIC_VEC_TRAP, NPIC_LVL3);
    serve(16'h0, 2'h0);
    en[9] <= 1'b0;
    step(2);
    @(negedge sys_clk);
    chk("pending", 16'h0, {2'h0, pend});
    en[9] <= 1'b1;
    flag  <= '0;
    clr   <= 14'h0200;
    step(1);
    clr   <= '0;
    ccw(NPIC_LVL0, 1'b1);
    serve(16'h0, 2'h0);
    // selected pins of group 0 are combined, latch cleared on entry
    sel  <= 16'h0016;
    pins <= 16'h0008;
    step(3);
    @(negedge sys_clk);
    chk("pending", 16'h0, {2'h0, pend});
    pins <= 16'h000A;
    step(2);
    @(negedge sys_clk);
    chk("pending", 16'h0004, {2'h0, pend});
    serve(va(2), fld[2]);
    chk("pending", 16'h0, {2'h0, pend});
    ccw(NPIC_LVL0, 1'b1);
    // halt: blocked source stays asleep, capable pin wakes, order after
    fld[3] = NPIC_LVL1;
    fld[8] = NPIC_LVL2;
    wfld();
    ehalt <= 1'b1;
    step(1);
    ehalt <= 1'b0;
    flag  <= 14'h0100;
    step(4);
    chk("halt_mode", 16'h1, {15'h0, hm});
    pins <= 16'h0010;
    step(3);
    chk("halt_mode", 16'h0, {15'h0, hm});
    serve(va(3), NPIC_LVL1);
    ccw(NPIC_LVL0, 1'b1);
    serve(va(8), NPIC_LVL2);
    flag <= '0;
    clr  <= 14'h0100;
    pins <= 16'h0;
    step(1);
    clr  <= '0;
    ccw(NPIC_LVL0, 1'b1);
    ehalt <= 1'b1;
    step(1);
    ehalt <= 1'b0;
    pulse_trap();
    step(3);
    chk("halt_mode", 16'h0, {15'h0, hm});
    serve(NPIC_VEC_TRAP, NPIC_LVL3);
    ccw(NPIC_LVL0, 1'b1);
    // wait mode ends on a source that cannot end halt
    ewait <= 1'b1;
    step(1);
    ewait <= 1'b0;
    flag  <= 14'h0400;
    step(4);
    chk("wait_mode", 16'h0, {15'h0, wm});
    serve(va(10), fld[10]);
    // second reset in mid-run
    rstn <= 1'b0;
    step(2);
    rstn <= 1'b1;
    wvl(NPIC_VEC_RESET, NPIC_LVL3);
    end_sim();
  end
endmodule : npic_ctrl_tb

`default_nettype wire
